// ==== hdl/option_word_pkg.sv ====
// Package: option word layout, register map, start-up timing constants and carrier types
package option_word_pkg;

   // Option word geometry and location in the test/configuration space
   localparam int OPTION_WIDTH = 14;
   localparam logic [13:0] OPTION_RESET = 14'h3fff;  // Erased part: every bit unprogrammed
   localparam logic [13:0] OPTION_WORD_INDEX = 14'h2007;
   localparam logic [13:0] TEST_SPACE_LOW_INDEX = 14'h2000;
   localparam logic [13:0] TEST_SPACE_HIGH_INDEX = 14'h3fff;

   // Field positions inside the option word
   localparam int OSC_SELECT_LOW_BIT = 0;
   localparam int OSC_SELECT_HIGH_BIT = 1;
   localparam int WATCHDOG_ENABLE_BIT = 2;
   localparam int POWER_UP_DELAY_ENABLE_BIT = 3;
   localparam int CODE_PROTECT_LOW_BIT = 4;
   localparam int CODE_PROTECT_HIGH_BIT = 5;

   // Register indices; byte address is four times the index
   localparam logic [13:0] CONTROL_INDEX = 14'h0000;
   localparam logic [13:0] STATUS_INDEX = 14'h0001;
   localparam int CTRL_SLEEP_BIT = 0;
   localparam int CTRL_WATCHDOG_CLEAR_BIT = 1;

   // Clock and start-up timing
   localparam int CLK_KHZ = 125000;
   localparam int POWER_UP_DELAY_MS = 72;
   localparam int POWER_UP_DELAY_CYCLES = POWER_UP_DELAY_MS * CLK_KHZ;
   localparam int OSC_STARTUP_CYCLES = 1024;
   localparam int WATCHDOG_TICKS = 2048;
   localparam int TIMER_WIDTH = 24;

   // Oscillator modes as coded in the select field
   typedef enum logic [1:0] {
      low_power_crystal_mode = 2'h0,
      crystal_resonator_mode = 2'h1,
      high_speed_crystal_mode = 2'h2,
      resistor_capacitor_mode = 2'h3
   } osc_mode_type;

   // Start-up sequence, Gray coded along the usual path
   typedef enum logic [1:0] {
      ST_POWER_UP = 2'h0,
      ST_OSC_START = 2'h1,
      ST_RUN = 2'h3,
      ST_SLEEP = 2'h2
   } startup_state_type;

   // Decoded options handed to the core
   typedef struct packed {
      osc_mode_type osc_mode;
      logic power_up_delay_enable;
      logic watchdog_enable;
      logic [1:0] code_protect;
   } options_type;

   // Wake and reset causes
   typedef struct packed {
      logic watchdog_reset;
      logic wake_by_watchdog;
      logic wake_by_interrupt;
      logic power_on;
   } cause_type;

endpackage

// ==== hdl/delay_counter.sv ====
// Tick counter that reports when a programmable limit is reached
`timescale 1ns/1ps
`default_nettype none

module delay_counter #(
   parameter int WIDTH = 24
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clear,
   input wire logic tick,
   input wire logic [WIDTH-1:0] limit,
   output logic done
);

   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] count_d;

   assign done = (count_q >= limit);

   // Count only while short of the limit, so the count never wraps
   always_comb begin
      count_d = count_q;
      if (clear) begin
         count_d = '0;
      end else if (tick && !done) begin
         count_d = count_q + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end

endmodule // delay_counter

`default_nettype wire

// ==== hdl/option_word_startup.sv ====
// Option word store, decode and start-up supervisor with an APB register port
`timescale 1ns/1ps
`default_nettype none

module option_word_startup #(
   parameter int POWER_UP_CYCLES = option_word_pkg::POWER_UP_DELAY_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic prog_mode_pin,
   input wire logic ext_reset_n_pin,
   input wire logic watchdog_osc_pin,
   input wire logic interrupt_wake,
   output logic core_reset,
   output logic sleeping,
   output option_word_pkg::options_type options
);
   import option_word_pkg::*;

   logic [13:0] option_q, option_d;
   logic [31:0] prdata_q, prdata_d;
   logic pslverr_q, pslverr_d;
   logic [2:0] sync1_q, sync1_d, sync2_q, sync2_d;
   logic wdt_last_q, wdt_last_d;
   startup_state_type state_q, state_d;
   cause_type cause_q, cause_d;
   logic prog_mode, ext_reset, wdt_tick;
   logic setup, access_wr;
   logic [13:0] index;
   logic in_test_space, is_option, is_control, is_status, mapped;
   logic power_up_delay_timer_done, ost_done, wdt_done;
   logic power_up_delay_timer_clear, ost_clear, wdt_clear, wdt_running;
   logic sleep_req, wdt_kick;
   logic [TIMER_WIDTH-1:0] power_up_delay_timer_limit, ost_limit, wdt_limit;

   // Pin synchronisers: the first stage feeds only the second
   always_comb begin
      sync1_d = {watchdog_osc_pin, ext_reset_n_pin, prog_mode_pin};
      sync2_d = sync1_q;
      wdt_last_d = sync2_q[2];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_q <= 3'h2;
         sync2_q <= 3'h2;
         wdt_last_q <= 1'b0;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         wdt_last_q <= wdt_last_d;
      end
   end

   assign prog_mode = sync2_q[0];
   assign ext_reset = !sync2_q[1];
   assign wdt_tick = sync2_q[2] && !wdt_last_q;

   // Decode; a zero in a bit means programmed
   assign options.osc_mode = osc_mode_type'({option_q[OSC_SELECT_HIGH_BIT],
                                             option_q[OSC_SELECT_LOW_BIT]});
   assign options.power_up_delay_enable = !option_q[POWER_UP_DELAY_ENABLE_BIT];
   assign options.watchdog_enable = option_q[WATCHDOG_ENABLE_BIT];
   assign options.code_protect = {option_q[CODE_PROTECT_HIGH_BIT],
                                  option_q[CODE_PROTECT_LOW_BIT]};

   // APB address decode on word indices
   assign index = paddr[15:2];
   assign setup = psel && !penable;
   assign access_wr = psel && penable && pwrite;
   assign in_test_space = (index >= TEST_SPACE_LOW_INDEX) && (index <= TEST_SPACE_HIGH_INDEX);
   assign is_option = (index == OPTION_WORD_INDEX) && prog_mode;
   assign is_control = (index == CONTROL_INDEX);
   assign is_status = (index == STATUS_INDEX);
   assign mapped = is_control || is_status || (in_test_space && prog_mode);

   // Control writes are pulses; watchdog clear and the sleep request both restart the watchdog count
   assign sleep_req = access_wr && is_control && pwdata[CTRL_SLEEP_BIT];
   assign wdt_kick = access_wr && is_control && pwdata[CTRL_WATCHDOG_CLEAR_BIT];

   // Read data and error are formed in setup so both come from flip-flops
   always_comb begin
      prdata_d = prdata_q;
      pslverr_d = pslverr_q;
      if (setup) begin
         pslverr_d = !mapped;
         prdata_d = 32'h0000_0000;
         if (is_option) begin
            prdata_d = {18'h00000, option_q};
         end else if (is_status) begin
            prdata_d = {24'h000000, cause_q, options.osc_mode, sleeping, core_reset};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q <= prdata_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign prdata = prdata_q;
   assign pslverr = pslverr_q;
   assign pready = 1'b1;

   // Programming can only clear bits, as an EPROM cell only goes from erased to programmed
   always_comb begin
      option_d = option_q;
      if (access_wr && is_option) begin
         option_d = option_q & pwdata[13:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         option_q <= OPTION_RESET;
      end else begin
         option_q <= option_d;
      end
   end

   // Start-up timers
   assign power_up_delay_timer_limit = TIMER_WIDTH'(POWER_UP_CYCLES);
   assign ost_limit = TIMER_WIDTH'(OSC_STARTUP_CYCLES);
   assign wdt_limit = TIMER_WIDTH'(WATCHDOG_TICKS);
   assign power_up_delay_timer_clear = (state_q != ST_POWER_UP);
   assign ost_clear = (state_q != ST_OSC_START) || ext_reset;
   assign wdt_running = options.watchdog_enable && ((state_q == ST_RUN) || (state_q == ST_SLEEP));
   assign wdt_clear = !wdt_running || wdt_kick || sleep_req || wdt_done;

   delay_counter #(.WIDTH(TIMER_WIDTH)) power_up_timer (
      .clk(clk),
      .rst(rst),
      .clear(power_up_delay_timer_clear),
      .tick(1'b1),
      .limit(power_up_delay_timer_limit),
      .done(power_up_delay_timer_done)
   );

   delay_counter #(.WIDTH(TIMER_WIDTH)) osc_start_timer (
      .clk(clk),
      .rst(rst),
      .clear(ost_clear),
      .tick(1'b1),
      .limit(ost_limit),
      .done(ost_done)
   );

   // Watchdog counts edges of its own oscillator, never the main clock
   delay_counter #(.WIDTH(TIMER_WIDTH)) watchdog_timer (
      .clk(clk),
      .rst(rst),
      .clear(wdt_clear),
      .tick(wdt_tick),
      .limit(wdt_limit),
      .done(wdt_done)
   );

   // Start-up and sleep sequencer; only rst (power-on) passes through the power-up delay
   always_comb begin
      state_d = state_q;
      cause_d = cause_q;
      unique case (state_q)
         ST_POWER_UP: begin
            if (power_up_delay_timer_done || !options.power_up_delay_enable) begin
               state_d = ST_OSC_START;
            end
         end
         ST_OSC_START: begin
            // RC needs no settling; crystal modes wait for the start-up count
            if (!ext_reset && (ost_done || options.osc_mode == resistor_capacitor_mode)) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (ext_reset) begin
               state_d = ST_OSC_START;
               cause_d = '0;
            end else if (wdt_running && wdt_done) begin
               state_d = ST_OSC_START;
               cause_d = '0;
               cause_d.watchdog_reset = 1'b1;
            end else if (sleep_req) begin
               state_d = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (ext_reset) begin
               state_d = ST_OSC_START;
               cause_d = '0;
            end else if (wdt_running && wdt_done) begin
               state_d = ST_OSC_START;
               cause_d.wake_by_watchdog = 1'b1;
            end else if (interrupt_wake) begin
               state_d = ST_OSC_START;
               cause_d.wake_by_interrupt = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= ST_POWER_UP;
         cause_q <= 4'h1;
      end else begin
         state_q <= state_d;
         cause_q <= cause_d;
      end
   end

   // Core is held in reset while in the power-up delay or oscillator start-up state
   assign core_reset = (state_q == ST_POWER_UP) || (state_q == ST_OSC_START);
   assign sleeping = (state_q == ST_SLEEP);

endmodule // option_word_startup

`default_nettype wire

// ==== testbench/programmer_model.sv ====
// Programmer and watchdog oscillator model on the far side of the block
`timescale 1ns/1ps
`default_nettype none
module programmer_model (
   input wire logic prog_req,
   output logic prog_mode_pin,
   output logic watchdog_osc_pin
);
   // Programming mode is held only while option access is wanted
   assign prog_mode_pin = prog_req;
   // Free-running RC oscillator, unrelated in phase to clk
   initial watchdog_osc_pin = 1'h0;
   always #10 watchdog_osc_pin = ~watchdog_osc_pin;
endmodule // programmer_model
`default_nettype wire

// ==== testbench/option_word_startup_assertions.sv ====
// Port checks for the option word block, bound after the module
`timescale 1ns/1ps
`default_nettype none
module option_word_checks #(
   parameter int POWER_UP_CYCLES = 20
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic [15:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic prog_mode_pin,
   input wire logic ext_reset_n_pin,
   input wire logic interrupt_wake,
   input wire logic core_reset,
   input wire logic sleeping,
   input wire option_word_pkg::options_type options
);
   import option_word_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [15:0] held_q;
   logic [15:0] held_d;
   logic setup;
   // Cycles the core has been held; saturates so a long hold never reads short
   always_comb held_d = core_reset ? held_q + {15'h0, ~&held_q} : 16'h0;
   always_ff @(posedge clk) held_q <= rst ? 16'h0 : held_d;
   assign setup = psel && !penable;
   pready_high_a: assert property (pready) else $error("pready low");
   lock_out_a: assert property (
      (!prog_mode_pin)[*4] ##0 (setup && paddr == 16'h801c) |=> pslverr && prdata == 32'h0)
      else $error("option word open");
   option_read_a: assert property (
      prog_mode_pin[*4] ##0 (setup && paddr == 16'h801c) |=> !pslverr && prdata[31:14] == 18'h0
      && prdata[2:0] == {options.watchdog_enable, options.osc_mode}) else $error("bad word");
   status_read_a: assert property (
      setup && paddr == 16'h0004 |=> prdata[1:0] == $past({sleeping, core_reset}))
      else $error("bad status");
   int_wake_a: assert property (sleeping && interrupt_wake |=> !sleeping)
      else $error("no interrupt wake");
   ext_hold_a: assert property ((!ext_reset_n_pin)[*5] |-> core_reset && !sleeping)
      else $error("no external hold");
   osc_hold_a: assert property ($fell(core_reset) &&
      options.osc_mode != resistor_capacitor_mode |-> held_q >= OSC_STARTUP_CYCLES)
      else $error("crystal start short");
   rc_hold_a: assert property ($fell(core_reset) &&
      options.osc_mode == resistor_capacitor_mode |-> held_q < POWER_UP_CYCLES)
      else $error("delay misapplied");
   sleep_c: cover property ($rose(sleeping));
   wake_c: cover property (sleeping && interrupt_wake);
   crystal_c: cover property ($fell(core_reset) && options.osc_mode != resistor_capacitor_mode);
endmodule // option_word_checks
bind option_word_startup option_word_checks #(.POWER_UP_CYCLES(POWER_UP_CYCLES)) chk (
   .clk(clk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .prog_mode_pin(prog_mode_pin),
   .ext_reset_n_pin(ext_reset_n_pin), .interrupt_wake(interrupt_wake),
   .core_reset(core_reset), .sleeping(sleeping), .options(options));
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the option word block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import option_word_pkg::*;
   localparam int PU = 20;
   logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic prog_req = 1'h0, ext_reset_n_pin = 1'h1, interrupt_wake = 1'h0;
   logic [15:0] paddr = 16'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd, err;
   logic pready, pslverr, prog_mode_pin, watchdog_osc_pin, core_reset, sleeping;
   options_type options;
   int failures = 0, checks = 0, seed = 32'hfa37;
   always #4 clk = ~clk;
   programmer_model partner (.prog_req(prog_req), .prog_mode_pin(prog_mode_pin),
      .watchdog_osc_pin(watchdog_osc_pin));
   option_word_startup #(.POWER_UP_CYCLES(PU)) dut (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .prog_mode_pin(prog_mode_pin),
      .ext_reset_n_pin(ext_reset_n_pin), .watchdog_osc_pin(watchdog_osc_pin),
      .interrupt_wake(interrupt_wake), .core_reset(core_reset), .sleeping(sleeping),
      .options(options));
   task automatic end_of_test();
      if (failures == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Bounded wait for core_reset (sel 0) or sleeping (sel 1) to drop
   task automatic wait_low(input bit sel, input int lim, output int n);
      for (n = 0; (sel ? sleeping : core_reset) !== 1'h0; n++) begin
         if (n == lim) begin
            cmp("wait", 32'h0, 32'h1);
            end_of_test();
         end
         @(posedge clk);
      end
   endtask
   // One APB transfer, held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [15:0] addr, input logic [31:0] data);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge clk);
      penable <= 1'h1;
      repeat (50) begin
         @(posedge clk);
         if (pready === 1'h1) break;
      end
      cmp("pready", 32'h1, {31'h0, pready});
      if (pready !== 1'h1) end_of_test();
      rd = prdata;
      err = {31'h0, pslverr};
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask
   // Synchronous reset held three cycles, then wait for the core to run
   task automatic do_reset();
      int n;
      rst <= 1'h1;
      prog_req <= 1'h0;
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      wait_low(1'h0, 50, n);
      repeat (4) @(posedge clk);
   endtask
   // External reset long enough to pass the pin synchroniser
   task automatic ext_pulse();
      ext_reset_n_pin <= 1'h0;
      repeat (5) @(posedge clk);
      ext_reset_n_pin <= 1'h1;
   endtask
   // Programming can only clear bits, so the word is the erased value masked
   function automatic logic [31:0] exp_word(input logic [31:0] wr);
      return {18'h0, OPTION_RESET & wr[13:0]};
   endfunction
   // Main sequence: lock-out, erased word, each oscillator code with one wake cause
   initial begin
      int n;
      logic [31:0] w;
      do_reset();
      cmp("osc", 32'h3, {30'h0, options.osc_mode});
      cmp("wdog", 32'h1, {31'h0, options.watchdog_enable});
      apb(1'h0, 16'h801c, 32'h0);
      cmp("locked", 32'h1, err);
      apb(1'h0, 16'h0100, 32'h0);
      cmp("unmapped", 32'h1, err);
      prog_req <= 1'h1;
      repeat (4) @(posedge clk);
      apb(1'h0, 16'h801c, 32'h0);
      cmp("erased", 32'h3fff, rd);
      apb(1'h0, 16'h8000, 32'h0);
      cmp("test space", 32'h0, rd | err);
      for (int c = 0; c < 4; c++) begin
         do_reset();
         prog_req <= 1'h1;
         repeat (4) @(posedge clk);
         w = $random(seed);
         w[3:0] = {1'h0, c[0], c[1:0]};
         apb(1'h1, 16'h801c, w);
         apb(1'h0, 16'h801c, 32'h0);
         cmp("word", exp_word(w), rd);
         cmp("mode", c, {30'h0, options.osc_mode});
         prog_req <= 1'h0;
         ext_pulse();
         wait_low(1'h0, 1200, n);
         cmp("hold", 32'h1, c == 3 ? n < PU : n >= OSC_STARTUP_CYCLES - 8);
         apb(1'h1, 16'h0000, 32'h1);
         cmp("asleep", 32'h1, {31'h0, sleeping});
         if (c == 0) interrupt_wake <= 1'h1;
         if (c == 1) wait_low(1'h1, 6000, n);
         if (c == 2) begin
            repeat (6000) @(posedge clk);
            cmp("no watchdog", 32'h1, {31'h0, sleeping});
         end
         if (c >= 2) ext_pulse();
         wait_low(1'h1, 20, n);
         interrupt_wake <= 1'h0;
         apb(1'h0, 16'h0004, 32'h0);
         cmp("cause", c == 0 ? 32'h1 : c == 1 ? 32'h2 : 32'h0, {30'h0, rd[6:5]});
         // A kick restarts the watchdog count; left alone it resets the running core
         if (c == 3) begin
            repeat (3000) @(posedge clk);
            apb(1'h1, 16'h0000, 32'h2);
            repeat (3000) @(posedge clk);
            apb(1'h0, 16'h0004, 32'h0);
            cmp("kicked", 32'h0, {28'h0, rd[7:4]});
            repeat (3000) @(posedge clk);
            apb(1'h0, 16'h0004, 32'h0);
            cmp("bite", 32'h8, {28'h0, rd[7:4]});
         end
      end
      end_of_test();
   end
endmodule // tb_top
`default_nettype wire
